/* File: design/epp_pkg.sv */
/*
 package for the epp cycle engine: register offsets, control and status
 bit positions, reset values, timing constants and carrier structs.
 assumes a 100 MHz system clock.
*/
package epp_pkg;

	localparam logic [2:0] off_data     = 3'h0;
	localparam logic [2:0] off_status   = 3'h1;
	localparam logic [2:0] off_control  = 3'h2;
	localparam logic [2:0] off_epp_addr = 3'h3;
	localparam logic [2:0] off_epp_data = 3'h4;

	localparam int bit_strobe   = 0;
	localparam int bit_autofeed = 1;
	localparam int bit_init     = 2;
	localparam int bit_selin    = 3;
	localparam int bit_irqe     = 4;
	localparam int bit_dir      = 5;
	localparam int bit_timeout  = 0;

	localparam logic [5:0] control_reset = 6'h00;
	localparam logic [7:0] data_reset    = 8'h00;

	localparam int clk_period_ns = 10;
	localparam int watchdog_us   = 10;
	localparam int watchdog_cycles = (watchdog_us * 1000) / clk_period_ns;
	localparam logic [10:0] watchdog_load = 11'(watchdog_cycles);

	typedef enum logic [1:0]
	{
		mode_spp   = 2'h0,
		mode_bidir = 2'h1,
		mode_epp19 = 2'h2,
		mode_epp17 = 2'h3
	} port_mode_t;

	typedef struct packed
	{
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed
	{
		logic       data_cycle_strobe_n;
		logic       addr_cycle_strobe_n;
		logic       write_direction_out_n;
		logic       strobe_n;
		logic       autofeed_n;
		logic       init_n;
		logic       select_in_n;
	} ctrl_pins_t;

endpackage

/* File: design/epp_watchdog.sv */
/*
 watchdog for epp cycles: loaded at start, counts down, flags expiry.
 assumes the engine holds run high for the guarded interval only.
*/
`timescale 1ns/1ps
module epp_watchdog
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic run,
	output logic      expired
);
	import epp_pkg::*;

	logic [10:0] count_q;

	// reload whenever idle, count while guarded
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !run)
			count_q <= watchdog_load;
		else if (count_q != 11'h000)
			count_q <= count_q - 11'h001;
	end

	assign expired = run && (count_q == 11'h000);

endmodule

/* File: design/epp_cycle_engine.sv */
/*
 epp cycle engine: turns register reads and writes at offsets 3..7 into
 epp address or data handshakes, holding the host until the peripheral
 answers or the watchdog trips. outside cycles the port is a plain
 standard or bidirectional parallel port.
 assumes one 100 MHz clock, synchronous pins, and a host that waits on
 the busy output before issuing the next access.
*/
// Design decisions made here: the strobed register port and the register offsets.
//
// Operation
// - outside epp cycles, pins follow control register; direction follows direction bit, except in spp mode where the bus is always driven.
// - epp 1.9 watchdog times start of cycle to hold line released.
// - watchdog expiry aborts the cycle and sets status bit 0.
// - active strobe bit forces write direction and write output during cycles; code leaves the write output on the direction bit in st_arm.
// - write with direction bit set becomes a read, no error flagged.
// - 1.9 write waits for hold line low before touching strobes.
// - 1.9 write drives byte and write first, then asserts strobe.
// - after hold line release, strobe drops and host write completes.
// - 1.9 read waits for hold line low before write or strobe.
// - 1.9 read floats bus, deasserts write, then asserts strobe.
// - on release, capture bus byte, drop strobe, return data to host.
// - epp 1.7 watchdog also times start of cycle to hold line released, 10 us.
// - 1.7 write follows direction bit, drives byte, stretches while line low.
// - 1.7 write ends by dropping strobe and holding byte on bus.
// - 1.7 read floats bus, strobes, stretches while line low, then ends.
// - write, strobes and reset outputs active low; interrupt passes uninverted.
// - only the write output and bus enable are overridable by control register in cycles.
// - timeout clears on status read when not selected, or on write one when selected.
// - offset 3 starts address cycles, offsets 4..7 data, epp mode only.
`timescale 1ns/1ps
module epp_cycle_engine
(
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire epp_pkg::port_mode_t  port_mode,
	input  wire logic                 timeout_clear_select,
	input  wire logic [2:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	output logic                      reg_busy,
	output logic                      reg_done,
	input  wire logic [7:0]           parallel_byte_in,
	output logic [7:0]                parallel_byte_out,
	output logic                      parallel_byte_oe_n,
	input  wire logic                 peripheral_hold_line_n,
	input  wire logic                 peripheral_interrupt_in,
	input  wire logic                 error_in_n,
	input  wire logic                 select_in,
	input  wire logic                 paper_end_in,
	input  wire logic                 ack_in_n,
	output epp_pkg::ctrl_pins_t       ctrl_pins,
	output logic                      peripheral_reset_n,
	output logic                      interrupt_request
);
	import epp_pkg::*;

	typedef enum logic [5:0]
	{
		st_idle   = 6'b000001,
		st_arm    = 6'b000010,
		st_setup  = 6'b000100,
		st_strobe = 6'b001000,
		st_finish = 6'b010000,
		st_ack    = 6'b100000
	} cycle_state_t;

	cycle_state_t state_q;
	cycle_state_t state_d;
	reg_req_t     req;
	logic [5:0]   control_q;
	logic [7:0]   data_q;
	logic [7:0]   latch_q;
	logic [7:0]   rdata_q;
	logic         done_q;
	logic         timeout_q;
	logic         is_addr_q;
	logic         is_write_q;
	logic         is_epp;
	logic         is_v17;
	logic         epp_hit;
	logic         start;
	logic         in_cycle;
	logic         wd_run;
	logic         wd_expired;
	logic         hold_low;
	logic         strobe_on;
	logic         drive_bus;
	logic         status_rd;
	logic [7:0]   status_byte;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign is_epp   = (port_mode == mode_epp19) || (port_mode == mode_epp17);
	assign is_v17   = (port_mode == mode_epp17);
	assign epp_hit  = is_epp && (req.addr >= off_epp_addr);
	assign start    = (state_q == st_idle) && epp_hit && (req.wr || req.rd);
	assign in_cycle = (state_q != st_idle);
	assign hold_low = !peripheral_hold_line_n;
	assign status_rd = req.rd && (req.addr == off_status) && !in_cycle;

	// 1.9 and 1.7 both guard start to release, not finish or ack
	assign wd_run = in_cycle && (state_q != st_finish) && (state_q != st_ack);

	epp_watchdog u_watchdog
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.run     (wd_run),
		.expired (wd_expired)
	);

	// cycle sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			st_idle:
				if (start)
					state_d = st_arm;
			st_arm:
				if (wd_expired)
					state_d = st_finish;
				else if (is_v17 || hold_low)
					state_d = st_setup;
			st_setup:
				state_d = st_strobe;
			st_strobe:
				if (wd_expired)
					state_d = st_finish;
				else if (!hold_low)
					state_d = st_finish;
			st_finish:
				state_d = st_ack;
			st_ack:
				state_d = st_idle;
			default:
				state_d = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_q <= st_idle;
		else
			state_q <= state_d;
	end

	// cycle kind captured at start; write with direction bit set reads instead
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			is_addr_q  <= 1'b0;
			is_write_q <= 1'b0;
		end
		else if (start)
		begin
			is_addr_q  <= (req.addr == off_epp_addr);
			is_write_q <= req.wr && !control_q[bit_dir];
		end
	end

	// control and data registers shared by standard and epp use
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			control_q <= control_reset;
			data_q    <= data_reset;
		end
		else if (req.wr && !in_cycle)
		begin
			if (req.addr == off_control)
				control_q <= req.wdata[5:0];
			if (req.addr == off_data)
				data_q <= req.wdata;
		end
	end

	// byte driven on the bus: epp write byte, latched through termination
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			latch_q <= data_reset;
		else if (start && req.wr)
			latch_q <= req.wdata;
		else if (req.wr && !in_cycle && req.addr == off_data)
			latch_q <= req.wdata;
	end

	// timeout flag: set wins over clear
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			timeout_q <= 1'b0;
		else if (wd_expired)
			timeout_q <= 1'b1;
		else if (!timeout_clear_select && status_rd)
			timeout_q <= 1'b0;
		else if (timeout_clear_select && req.wr && !in_cycle && req.addr == off_status
			&& req.wdata[bit_timeout])
			timeout_q <= 1'b0;
	end

	assign status_byte = {!peripheral_hold_line_n, ack_in_n, paper_end_in, select_in,
		error_in_n, 2'b00, timeout_q};

	// read data: captured byte on release, or register contents
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rdata_q <= 8'h00;
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= (state_q == st_finish) || (req.rd && !in_cycle && !start)
				|| (req.wr && !in_cycle && !start);
			if (state_q == st_strobe && !hold_low && !is_write_q)
				rdata_q <= parallel_byte_in;
			else if (req.rd && !in_cycle && !start)
			begin
				case (req.addr)
					off_data:    rdata_q <= parallel_byte_in;
					off_status:  rdata_q <= status_byte;
					off_control: rdata_q <= {2'b00, control_q};
					default:     rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_done  = done_q;
	assign reg_busy  = in_cycle;

	// pin drive
	assign strobe_on = (state_q == st_strobe);
	assign drive_bus = in_cycle ? (is_write_q || control_q[bit_strobe])
		: (port_mode == mode_spp) || !control_q[bit_dir];

	always_comb
	begin
		ctrl_pins.strobe_n      = !control_q[bit_strobe];
		ctrl_pins.autofeed_n    = !control_q[bit_autofeed];
		ctrl_pins.init_n        = control_q[bit_init];
		ctrl_pins.select_in_n   = !control_q[bit_selin];
		ctrl_pins.data_cycle_strobe_n = !(strobe_on && !is_addr_q);
		ctrl_pins.addr_cycle_strobe_n = !(strobe_on && is_addr_q);
		if (in_cycle && state_q != st_arm)
			ctrl_pins.write_direction_out_n = !(is_write_q || control_q[bit_strobe]);
		else
			ctrl_pins.write_direction_out_n = control_q[bit_dir];
		if (is_epp && in_cycle)
		begin
			ctrl_pins.autofeed_n  = ctrl_pins.data_cycle_strobe_n;
			ctrl_pins.select_in_n = ctrl_pins.addr_cycle_strobe_n;
		end
	end

	assign parallel_byte_out  = latch_q;
	assign parallel_byte_oe_n = !drive_bus;
	assign peripheral_reset_n = control_q[bit_init];
	assign interrupt_request  = peripheral_interrupt_in && control_q[bit_irqe];

endmodule

/* File: testbench/epp_cycle_engine_assertions.sv */
/*
 port assertions for the epp cycle engine.
 assumes one clock domain and a bind onto the engine.
*/
`timescale 1ns/1ps
module epp_cycle_engine_assertions
(
	input wire logic                ref_clk,
	input wire logic                sys_rst,
	input wire epp_pkg::port_mode_t port_mode,
	input wire logic [2:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_busy,
	input wire logic                parallel_byte_oe_n,
	input wire logic                peripheral_hold_line_n,
	input wire logic                peripheral_interrupt_in,
	input wire epp_pkg::ctrl_pins_t ctrl_pins,
	input wire logic                peripheral_reset_n,
	input wire logic                interrupt_request
);
	import epp_pkg::*;
	logic [5:0]  ctl_q;
	logic [10:0] cnt_q;
	wire         stb_n = ctrl_pins.data_cycle_strobe_n & ctrl_pins.addr_cycle_strobe_n;
	wire         wr_n = ctrl_pins.write_direction_out_n;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ctl_q <= 6'h00;
		else if (reg_wr && !reg_busy && reg_addr == off_control)
			ctl_q <= reg_wdata[5:0];
	end
	always_ff @(posedge ref_clk)
	begin
		cnt_q <= (sys_rst || !reg_busy) ? 11'h000 : cnt_q + 11'h001;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_excl; ctrl_pins.data_cycle_strobe_n | ctrl_pins.addr_cycle_strobe_n; endproperty
	property p_wr; $fell(stb_n) && !wr_n |-> $past(!wr_n) && !parallel_byte_oe_n; endproperty
	property p_rd; $fell(stb_n) && wr_n |-> parallel_byte_oe_n && $past(parallel_byte_oe_n);
	endproperty
	property p_wait; $fell(stb_n) && port_mode == mode_epp19 |-> $past(!peripheral_hold_line_n);
	endproperty
	property p_end; !stb_n && peripheral_hold_line_n |-> ##[1:3] stb_n; endproperty
	property p_wdog; cnt_q <= 11'h3f2; endproperty
	property p_idle; !reg_busy |-> ctrl_pins.strobe_n == !ctl_q[0] && ctrl_pins.init_n == ctl_q[2]
		&& ctrl_pins.autofeed_n == !ctl_q[1]; endproperty
	property p_pins; interrupt_request == (peripheral_interrupt_in && ctl_q[4])
		&& peripheral_reset_n == ctl_q[2]; endproperty
	property p_force; !stb_n && ctl_q[0] |-> !wr_n && !parallel_byte_oe_n; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	a_wr: assert property (p_wr) else $error("write setup order");
	a_rd: assert property (p_rd) else $error("read bus not floated");
	a_wait: assert property (p_wait) else $error("strobe before hold low");
	a_end: assert property (p_end) else $error("strobe kept after release");
	a_wdog: assert property (p_wdog) else $error("cycle not aborted");
	a_idle: assert property (p_idle) else $error("idle pins wrong");
	a_pins: assert property (p_pins) else $error("reset or irq pin wrong");
	a_force: assert property (p_force) else $error("strobe bit not forcing write");
	c_wr: cover property (!stb_n && !wr_n);
	c_rd: cover property (!stb_n && wr_n);
	c_wdog: cover property (cnt_q > 11'h384);
endmodule
bind epp_cycle_engine epp_cycle_engine_assertions u_chk
(
	.ref_clk(ref_clk), .sys_rst(sys_rst), .port_mode(port_mode), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_busy(reg_busy),
	.parallel_byte_oe_n(parallel_byte_oe_n), .peripheral_hold_line_n(peripheral_hold_line_n),
	.peripheral_interrupt_in(peripheral_interrupt_in), .ctrl_pins(ctrl_pins),
	.peripheral_reset_n(peripheral_reset_n), .interrupt_request(interrupt_request)
);

/* File: testbench/epp_peer.sv */
/*
 epp peripheral model: answers a strobe dly+1 cycles after it falls, or never.
 assumes one combined active-low strobe from the engine.
*/
`timescale 1ns/1ps
module epp_peer
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       stb_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] dout,
	input  wire logic       oe_n,
	input  wire logic [7:0] rd_byte,
	input  wire logic [3:0] dly,
	input  wire logic       stall,
	input  wire logic       pre_hi,
	output logic [7:0]      din,
	output logic            hold_n,
	output logic [7:0]      got,
	output logic            saw_wr
);
	logic [3:0] cnt_q;
	logic [7:0] flt_q;
	// bus level: engine, else peer during read strobe, else floating
	assign din = !oe_n ? dout : (!stb_n && wr_n) ? rd_byte : flt_q;
	always_ff @(posedge ref_clk)
	begin
		flt_q <= sys_rst ? 8'h5a : ~flt_q;
		cnt_q <= (sys_rst || stb_n) ? 4'h0 : cnt_q + 4'h1;
		if (sys_rst || stb_n)
			hold_n <= pre_hi && !sys_rst;
		else if (cnt_q == dly && !stall)
			hold_n <= 1'b1;
		if (!stb_n)
			saw_wr <= !wr_n;
		if (!stb_n && !wr_n)
			got <= dout;
	end
endmodule

/* File: testbench/epp_cycle_engine_tb.sv */
/*
 self-checking bench for the epp cycle engine.
 assumes the checker and peripheral model are compiled before it.
*/
`timescale 1ns/1ps
module epp_cycle_engine_tb;
	import epp_pkg::*;
	logic       ref_clk, sys_rst, tsel, reg_wr, reg_rd, hold_n, irq_in, busy, done;
	logic       err_n, sel, pe, ack_n, oe_n, rst_n, irq, stall, pre_hi, saw_wr;
	logic [2:0] reg_addr;
	logic [3:0] dly;
	logic [7:0] reg_wdata, reg_rdata, dout, din, rd_byte, got, rdat, v;
	port_mode_t mode;
	ctrl_pins_t pins;
	int         n_errors, n_compared, cyc, m, a;
	integer     seed;
	epp_cycle_engine u_dut
	(
		.ref_clk(ref_clk), .sys_rst(sys_rst), .port_mode(mode), .timeout_clear_select(tsel),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_busy(busy), .reg_done(done), .parallel_byte_in(din),
		.parallel_byte_out(dout), .parallel_byte_oe_n(oe_n), .peripheral_hold_line_n(hold_n),
		.peripheral_interrupt_in(irq_in), .error_in_n(err_n), .select_in(sel),
		.paper_end_in(pe), .ack_in_n(ack_n), .ctrl_pins(pins), .peripheral_reset_n(rst_n),
		.interrupt_request(irq)
	);
	epp_peer u_peer
	(
		.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_n(pins.write_direction_out_n),
		.stb_n(pins.data_cycle_strobe_n & pins.addr_cycle_strobe_n), .dout(dout),
		.oe_n(oe_n), .rd_byte(rd_byte), .dly(dly), .stall(stall), .pre_hi(pre_hi),
		.din(din), .hold_n(hold_n), .got(got), .saw_wr(saw_wr)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [2:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= adr;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 1200)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n == 1200)
			check("done in time", 8'h00, 8'h01);
		rdat = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic st(input logic t);
		acc(1'b0, off_status, 8'h00);
		check("status", rdat & 8'h7f, {1'b0, ack_n, pe, sel, err_n, 2'b00, t});
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		seed = 32'hb07945df;
		{sys_rst, tsel, reg_wr, reg_rd, irq_in, stall, pre_hi} = 7'h40;
		{err_n, sel, pe, ack_n} = 4'ha;
		{reg_addr, reg_wdata, rd_byte, dly} = '0;
		mode = mode_spp;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		acc(1'b0, off_control, 8'h00);
		check("control", rdat, {2'b00, control_reset});
		for (m = 0; m < 4; m++)
		begin
			v = $random(seed);
			{err_n, sel, pe, ack_n, irq_in} <= v[4:0];
			acc(1'b1, off_data, v);
			acc(1'b0, off_data, 8'h00);
			check("data", rdat, v);
			acc(1'b1, off_control, v);
			acc(1'b0, off_control, 8'h00);
			check("control", rdat, {2'b00, v[5:0]});
			st(1'b0);
		end
		acc(1'b0, off_epp_data, 8'h00);
		check("offset 4 outside epp", rdat, 8'h00);
		$display("test plain registers done");
		for (m = 0; m < 2; m++)
		begin
			mode <= m ? mode_epp17 : mode_epp19;
			for (a = 3; a < 8; a++)
			begin
				v = $random(seed);
				dly <= v[3:0];
				rd_byte <= ~v;
				acc(1'b1, off_control, 8'h04);
				acc(1'b1, a[2:0], v);
				check("written byte", got, v);
				if (m)
					check("held byte", dout, v);
				acc(1'b1, off_control, m ? 8'h24 : 8'h04);
				acc(1'b0, a[2:0], 8'h00);
				check("read byte", rdat, ~v);
				st(1'b0);
			end
		end
		$display("test epp transfers done");
		mode <= mode_epp19;
		acc(1'b1, off_control, 8'h24);
		acc(1'b1, off_epp_data, 8'h3c);
		check("write seen", {7'h00, saw_wr}, 8'h00);
		st(1'b0);
		acc(1'b1, off_control, 8'h05);
		acc(1'b0, off_epp_data, 8'h00);
		check("forced write", {7'h00, saw_wr}, 8'h01);
		acc(1'b1, off_control, 8'h04);
		pre_hi <= 1'b1;
		repeat (2) @(posedge ref_clk);
		fork
			acc(1'b1, off_epp_addr, 8'h81);
			begin
				repeat (30) @(posedge ref_clk);
				pre_hi <= 1'b0;
			end
		join
		check("late byte", got, 8'h81);
		$display("test direction and wait done");
		for (m = 0; m < 2; m++)
		begin
			mode <= m ? mode_epp17 : mode_epp19;
			tsel <= m[0];
			stall <= 1'b1;
			acc(1'b1, off_epp_data, 8'h11);
			stall <= 1'b0;
			st(1'b1);
			st(m[0]);
			acc(1'b1, off_status, 8'h01);
			st(1'b0);
		end
		$display("test watchdog done");
		tally_and_finish();
	end
endmodule
